// ### cs_one_ctrl.sv
// Purpose: Chip select 1 configuration register and external access sequencer
// Assumes: All inputs synchronous to clk; ext_wait high asks for more wait cycles
// Notes:   Configuration is sampled when an access is taken, except the recovery settings, read when it ends
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module cs_one_ctrl (
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Access request port
	input  wire logic        acc_req,
	input  wire logic        acc_write,
	input  wire logic [15:0] acc_wdata,
	output logic             acc_ready,
	output logic             acc_done,
	output logic             acc_refused,
	output logic      [15:0] acc_rdata,
	// External memory side
	output logic             chip_select_one_n,
	output logic             mem_rd_n,
	output logic             mem_wr_n,
	output logic             mem_bus_8bit,
	output logic      [15:0] mem_wdata,
	output logic             mem_wdata_oe,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        ext_wait
);

	typedef struct packed {
		cs_one_pkg::state_e st;
		logic [3:0]         cnt;
		logic               ext_mode;
		logic               is_write;
		logic [1:0]         waveform;
		logic               bus_8bit;
		logic [3:0]         wait_code;
		logic               region_en;
		logic [1:0]         write_recov;
		logic [1:0]         read_recov;
		logic               release_recov;
		logic [31:0]        rdata;
		logic               ready;
		logic               done;
		logic               refused;
		logic [15:0]        acc_rdata;
		logic               cs_n;
		logic               rd_n;
		logic               wr_n;
		logic               bus8_out;
		logic [15:0]        wdata;
		logic               oe;
	} state_s;

	state_s s_q;
	state_s s_d;

	// Block overview
	//
	// Configuration word layout, upper half only:
	//   19:16  wait code
	//   20     bus width, 0 for 16-bit, 1 for 8-bit
	//   21     unused, reads zero
	//   23:22  output waveform, only the ROM/RAM code is legal
	//   25:24  read recovery code
	//   26     unused, reads zero
	//   27     region enable
	//   29:28  write recovery code
	//   30     release recovery cycle
	//   31     unused, reads zero
	// Bits 15:0 belong to another region and read zero from this block.
	//
	// Register port behaviour:
	//   A write lands at the edge that samples the strobe.
	//   A read answers in the next cycle only; otherwise read data is zero.
	//   Other offsets are ignored on write and read back as zero.
	//   A write and an access taken at the same edge see the old settings.
	//
	// Access walk, enabled region, W automatic waits:
	//   Edge 0: request taken while ready is high.
	//   Cycle 1: chip select and the strobe go low, ready goes low.
	//   Cycles 2 to W+1: strobe held while the wait count runs down.
	//   Last strobe cycle: read data captured from the memory bus.
	//   Next cycle: chip select and strobes high, done pulses.
	//   Then recovery, or ready high at once when no recovery is due.
	//
	// Disabled region:
	//   Done and refused pulse together one cycle after the request.
	//   Chip select never moves and ready stays high.
	//
	// Wait codes:
	//   0 to 7 give that many automatic waits.
	//   8 and 9 are reserved and run with no waits at all.
	//   10 to 15 give code minus 8 minimum waits, then external extension.
	//
	// External extension:
	//   Once the minimum count has run out the wait input is sampled.
	//   Each high sample adds two cycles, then the input is looked at again.
	//   A memory that holds the input high forever holds the bus forever;
	//   the block has no watchdog of its own.
	//
	// Recovery:
	//   Read or write code 00 gives two cycles, 01 one, anything else none.
	//   The release bit adds one more cycle on top.
	//   Chip select stays high for the whole recovery time.
	//   A request offered during recovery is dropped, not queued.
	//
	// Settings captured at acceptance:
	//   Wait count, external mode, bus width and the write data.
	//   Recovery codes are read when the access ends, so a write to the
	//   register during an access changes the recovery of that access.
	//
	// Bus width:
	//   In 8-bit mode only the low byte is driven; the high byte is zero.
	//   Read data in 8-bit mode comes from the low byte with zero above.
	//
	// Write data drive:
	//   The drive enable is high only while a write holds the bus.
	//   It falls with chip select so the memory can turn the bus around.
	//
	// Reset:
	//   All strobes inactive, drive enable low, ready high.
	//   Configuration cleared, so the region starts disabled.
	//   The first request may come at the first edge after release.
	//
	// Hazards:
	//   Reserved wait codes are not refused; software must avoid them.
	//   The waveform field is stored and read back but does not act.
	//   No interrupt and no error flag; the refused pulse is the only sign.
	//
	// Structure:
	//   All state lives in one packed struct.
	//   One combinational process builds the next copy.
	//   One clocked process registers it, so every output is a flip-flop.
	//
	// Counter width:
	//   Four bits cover seven waits and three recovery cycles.
	//   The external step reloads one so each sample costs two cycles.
	//
	// Timing of outputs:
	//   Done, refused and read data change only at clock edges.
	//   Read data from an access holds until the next read access ends.

	// Recovery code to cycle count
	function automatic logic [3:0] recov_cycles(input logic [1:0] code);
		case (code)
			cs_one_pkg::RECOV_TWO: recov_cycles = 4'h2;
			cs_one_pkg::RECOV_ONE: recov_cycles = 4'h1;
			default:               recov_cycles = 4'h0;
		endcase
	endfunction

	// Wait code to minimum wait count
	function automatic logic [3:0] min_waits(input logic [3:0] code);
		if (code < cs_one_pkg::WAIT_EXT_BASE) begin
			min_waits = code;
		end else if (code <= cs_one_pkg::WAIT_RSVD_HI) begin
			min_waits = 4'h0;
		end else begin
			min_waits = code - cs_one_pkg::WAIT_EXT_BASE;
		end
	endfunction

	// Register image with unused bits at zero
	function automatic logic [31:0] cfg_word(input state_s s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[cs_one_pkg::WAIT_LSB +: 4]         = s.wait_code;
		w[cs_one_pkg::BUS_WIDTH_BIT]         = s.bus_8bit;
		w[cs_one_pkg::WAVEFORM_LSB +: 2]     = s.waveform;
		w[cs_one_pkg::READ_RECOV_LSB +: 2]   = s.read_recov;
		w[cs_one_pkg::REGION_EN_BIT]         = s.region_en;
		w[cs_one_pkg::WRITE_RECOV_LSB +: 2]  = s.write_recov;
		w[cs_one_pkg::RELEASE_RECOV_BIT]     = s.release_recov;
		cfg_word = w;
	endfunction

	// Next state
	always_comb begin
		logic [3:0] total;
		total = 4'h0;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.refused = 1'b0;
		s_d.rdata = 32'h0000_0000;

		// Register write and read
		if (reg_wr && reg_addr == cs_one_pkg::CFG_OFFSET) begin
			s_d.wait_code     = reg_wdata[cs_one_pkg::WAIT_LSB +: 4];
			s_d.bus_8bit      = reg_wdata[cs_one_pkg::BUS_WIDTH_BIT];
			s_d.waveform      = reg_wdata[cs_one_pkg::WAVEFORM_LSB +: 2];
			s_d.read_recov    = reg_wdata[cs_one_pkg::READ_RECOV_LSB +: 2];
			s_d.region_en     = reg_wdata[cs_one_pkg::REGION_EN_BIT];
			s_d.write_recov   = reg_wdata[cs_one_pkg::WRITE_RECOV_LSB +: 2];
			s_d.release_recov = reg_wdata[cs_one_pkg::RELEASE_RECOV_BIT];
		end
		if (reg_rd && reg_addr == cs_one_pkg::CFG_OFFSET) begin
			s_d.rdata = cfg_word(s_q);
		end

		// Access sequencer
		case (s_q.st)
			cs_one_pkg::ST_IDLE: begin
				if (acc_req && s_q.ready) begin
					if (!s_q.region_en) begin
						s_d.refused = 1'b1;
						s_d.done = 1'b1;
					end else begin
						s_d.st       = cs_one_pkg::ST_STROBE;
						s_d.ready    = 1'b0;
						s_d.is_write = acc_write;
						s_d.cnt      = min_waits(s_q.wait_code);
						s_d.ext_mode = s_q.wait_code > cs_one_pkg::WAIT_RSVD_HI;
						s_d.cs_n     = 1'b0;
						s_d.rd_n     = acc_write;
						s_d.wr_n     = !acc_write;
						s_d.bus8_out = s_q.bus_8bit;
						s_d.wdata    = s_q.bus_8bit ? {8'h00, acc_wdata[7:0]} : acc_wdata;
						s_d.oe       = acc_write;
					end
				end
			end
			cs_one_pkg::ST_STROBE, cs_one_pkg::ST_WAIT: begin
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
					s_d.st = cs_one_pkg::ST_WAIT;
				end else if (s_q.ext_mode && ext_wait) begin
					s_d.cnt = cs_one_pkg::EXT_WAIT_STEP;
					s_d.st = cs_one_pkg::ST_WAIT;
				end else begin
					s_d.cs_n = 1'b1;
					s_d.rd_n = 1'b1;
					s_d.wr_n = 1'b1;
					s_d.oe   = 1'b0;
					s_d.done = 1'b1;
					if (!s_q.is_write) begin
						s_d.acc_rdata = s_q.bus8_out ? {8'h00, mem_rdata[7:0]} : mem_rdata;
					end
					total = s_q.is_write ? recov_cycles(s_q.write_recov)
					                     : recov_cycles(s_q.read_recov);
					total = total + {3'h0, s_q.release_recov};
					if (total == 4'h0) begin
						s_d.st = cs_one_pkg::ST_IDLE;
						s_d.ready = 1'b1;
					end else begin
						s_d.st = cs_one_pkg::ST_RECOV;
						s_d.cnt = total;
					end
				end
			end
			cs_one_pkg::ST_RECOV: begin
				// Chip select stays high until the count runs out
				if (s_q.cnt <= 4'h1) begin
					s_d.st = cs_one_pkg::ST_IDLE;
					s_d.ready = 1'b1;
					s_d.cnt = 4'h0;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			default: begin
				s_d.st = cs_one_pkg::ST_IDLE;
				s_d.ready = 1'b1;
				s_d.cs_n = 1'b1;
				s_d.rd_n = 1'b1;
				s_d.wr_n = 1'b1;
				s_d.oe = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{st: cs_one_pkg::ST_IDLE, cnt: 4'h0, ext_mode: 1'b0, is_write: 1'b0,
			         waveform: cs_one_pkg::WAVE_ROM_RAM, bus_8bit: 1'b0, wait_code: 4'h0,
			         region_en: 1'b0, write_recov: 2'h0, read_recov: 2'h0,
			         release_recov: 1'b0, rdata: cs_one_pkg::CFG_RESET, ready: 1'b1,
			         done: 1'b0, refused: 1'b0, acc_rdata: 16'h0000, cs_n: 1'b1,
			         rd_n: 1'b1, wr_n: 1'b1, bus8_out: 1'b0, wdata: 16'h0000, oe: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata         = s_q.rdata;
	assign acc_ready         = s_q.ready;
	assign acc_done          = s_q.done;
	assign acc_refused       = s_q.refused;
	assign acc_rdata         = s_q.acc_rdata;
	assign chip_select_one_n = s_q.cs_n;
	assign mem_rd_n          = s_q.rd_n;
	assign mem_wr_n          = s_q.wr_n;
	assign mem_bus_8bit      = s_q.bus8_out;
	assign mem_wdata         = s_q.wdata;
	assign mem_wdata_oe      = s_q.oe;

endmodule

// ### cs_one_pkg.sv
// Purpose: Constants for the chip select 1 configuration and access timing block
// Assumes: 20 MHz clock, one 32-bit configuration register on a plain port
// Notes:   Lower half of the register belongs to another region and reads as zero here
package cs_one_pkg;
	localparam logic [7:0]  CFG_OFFSET       = 8'h00;
	localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
	// Field positions within the configuration word
	localparam int          WAIT_LSB         = 16;
	localparam int          BUS_WIDTH_BIT    = 20;
	localparam int          WAVEFORM_LSB     = 22;
	localparam int          READ_RECOV_LSB   = 24;
	localparam int          REGION_EN_BIT    = 27;
	localparam int          WRITE_RECOV_LSB  = 28;
	localparam int          RELEASE_RECOV_BIT = 30;
	// Codes
	localparam logic [1:0]  RECOV_TWO        = 2'h0;
	localparam logic [1:0]  RECOV_ONE        = 2'h1;
	localparam logic [1:0]  WAVE_ROM_RAM     = 2'h0;
	localparam logic [3:0]  WAIT_EXT_BASE    = 4'h8;
	localparam logic [3:0]  WAIT_RSVD_HI     = 4'h9;
	localparam logic [3:0]  EXT_WAIT_STEP    = 4'h1;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_STROBE = 2'h1,
		ST_WAIT   = 2'h3,
		ST_RECOV  = 2'h2
	} state_e;
endpackage

// ### cs_one_mem_model.sv
// Purpose: External memory stand-in for chip select 1
// Assumes: Data is driven only while selected with the read strobe low
// Notes:   A released bus shows inverted data so a stale sample cannot pass
`timescale 1ns/1ps
module cs_one_mem_model #(
	parameter logic [15:0] DATA = 16'hA5C3
) (
	input  wire logic        clk,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic [7:0]  stretch,
	output logic      [15:0] rdata,
	output logic             ext_wait
);
	logic [7:0] n_q;
	// Counts the cycles of the current selection
	always_ff @(posedge clk) begin
		n_q <= cs_n ? 8'h0 : n_q + 8'h1;
	end
	// Wait held for the first stretch cycles; bus released outside reads
	assign ext_wait = !cs_n && n_q < stretch;
	assign rdata    = (!cs_n && !rd_n) ? DATA : ~DATA;
endmodule

// ### cs_one_ctrl_props.sv
// Purpose: Port checks for the chip select 1 sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every sequencer instance
`timescale 1ns/1ps
module cs_one_ctrl_props (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        acc_req,
	input wire logic        acc_ready,
	input wire logic        acc_done,
	input wire logic        acc_refused,
	input wire logic        chip_select_one_n,
	input wire logic        mem_rd_n,
	input wire logic        mem_wr_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_unused_zero: assert property (reg_rdata[15:0] == 16'h0 && !reg_rdata[31]
		&& !reg_rdata[26] && !reg_rdata[21]) else $error("unused bits set");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read");
	a_refuse_idle: assert property (acc_refused |-> acc_done && chip_select_one_n
		&& $past(chip_select_one_n)) else $error("refused access selected");
	a_start_taken: assert property (acc_req && acc_ready |=> !chip_select_one_n
		|| acc_refused) else $error("request not started");
	a_one_strobe: assert property (!chip_select_one_n |-> mem_rd_n != mem_wr_n)
		else $error("strobe pair wrong");
	a_done_release: assert property (acc_done && !acc_refused |-> chip_select_one_n
		&& !$past(chip_select_one_n)) else $error("done without release");
	a_ready_idle: assert property (acc_ready |-> chip_select_one_n)
		else $error("ready while selected");
	a_strobe_held: assert property (!chip_select_one_n && !$fell(chip_select_one_n)
		|-> $stable(mem_rd_n) && $stable(mem_wr_n)) else $error("strobe moved");
endmodule
bind cs_one_ctrl cs_one_ctrl_props chk_u (.clk, .arst_n, .reg_rd, .reg_rdata, .acc_req,
	.acc_ready, .acc_done, .acc_refused, .chip_select_one_n, .mem_rd_n, .mem_wr_n);

// ### test_chip_select_wait_config.sv
// Purpose: Self-checking bench for the chip select 1 sequencer
// Assumes: 20 MHz clock, memory model on the far side
// Notes:   Measures strobe and recovery lengths per access
`timescale 1ns/1ps
module test_chip_select_wait_config;
	localparam logic [15:0] DATA = 16'hA5C3;
	logic clk, arst_n, reg_wr, reg_rd, acc_req, acc_write, ext_wait, cur_8bit;
	logic [7:0] reg_addr, stretch;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] acc_wdata, acc_rdata, mem_rdata, mem_wdata;
	logic mem_wdata_oe;
	logic acc_ready, acc_done, acc_refused, chip_select_one_n, mem_rd_n, mem_wr_n, mem_bus_8bit;
	int n_errors = 0;
	int n_compared = 0;
	int i;
	cs_one_ctrl dut_u (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.acc_req, .acc_write, .acc_wdata, .acc_ready, .acc_done, .acc_refused, .acc_rdata,
		.chip_select_one_n, .mem_rd_n, .mem_wr_n, .mem_bus_8bit, .mem_wdata,
		.mem_wdata_oe, .mem_rdata, .ext_wait);
	cs_one_mem_model #(.DATA(DATA)) mem_u (.clk, .cs_n(chip_select_one_n), .rd_n(mem_rd_n),
		.stretch, .rdata(mem_rdata), .ext_wait);
	// Clock generation
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 if (!w) check("reg_rdata", d, reg_rdata);
	endtask
	// Waveform field always 00
	task automatic cfg(logic [3:0] wt, logic b8, logic [1:0] rr, logic [1:0] wr, logic rel,
		logic en);
		cur_8bit = b8;
		bus(1'b1, 8'h00, {1'b0, rel, wr, en, 1'b0, rr, 2'h0, 1'b0, b8, wt, 16'h0});
	endtask
	task automatic acc(logic w, int wt, int rec, logic refuse, logic ext);
		int n, r, k;
		n = 0;
		r = 0;
		@(posedge clk);
		acc_req <= 1'b1;
		acc_write <= w;
		@(posedge clk);
		acc_req <= 1'b0;
		#1;
		for (k = 0; k < 60 && acc_done !== 1'b1; k++) begin
			n += (chip_select_one_n === 1'b0);
			if (chip_select_one_n === 1'b0) check("bus_8bit", cur_8bit, mem_bus_8bit);
			if (chip_select_one_n === 1'b0) check("mem_wr_n", !w, mem_wr_n);
			if (chip_select_one_n === 1'b0) check("mem_rd_n", w, mem_rd_n);
			if (chip_select_one_n === 1'b0) check("mem_wdata_oe", w, mem_wdata_oe);
			if (chip_select_one_n === 1'b0 && w) check("mem_wdata",
				cur_8bit ? {8'h0, acc_wdata[7:0]} : acc_wdata, mem_wdata);
			@(posedge clk);
			#1;
		end
		if (k == 60) begin
			check("acc_done", 1, acc_done);
			give_verdict();
		end
		check("acc_refused", refuse, acc_refused);
		if (ext) check("ext_stretch", 1, n > wt + 1 && (n - wt - 1) % 2 == 0);
		else check("strobe_cycles", refuse ? 0 : wt + 1, n);
		if (!w && !refuse) check("acc_rdata", cur_8bit ? {8'h0, DATA[7:0]} : DATA, acc_rdata);
		for (k = 0; k < 60 && acc_ready !== 1'b1; k++) begin
			@(posedge clk);
			#1;
			r += (chip_select_one_n === 1'b1) ? 1 : 100;
		end
		check("recovery", rec, r);
		if (k == 60) give_verdict();
	endtask
	// Main sequence
	initial begin
		{arst_n, reg_wr, reg_rd, acc_req, acc_write, cur_8bit} = 6'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		acc_wdata = 16'h5A3C;
		stretch = 8'h0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		bus(1'b0, 8'h00, 32'h0);
		bus(1'b1, 8'h00, 32'hFF3F_FFFF);
		bus(1'b0, 8'h00, 32'h7B1F_0000);
		bus(1'b0, 8'h04, 32'h0);
		cfg(4'h0, 1'b0, 2'h2, 2'h2, 1'b0, 1'b0);
		acc(1'b0, 0, 0, 1'b1, 1'b0);
		for (i = 0; i < 16; i++) begin
			cfg(i[3:0], i[0], 2'h2, 2'h2, 1'b0, 1'b1);
			acc(i[1], i < 8 ? i : (i < 10 ? 0 : i - 8), 0, 1'b0, 1'b0);
		end
		for (i = 0; i < 8; i++) begin
			cfg(4'h0, 1'b0, i[1:0], i[1:0], i[2], 1'b1);
			acc(1'b0, 0, (i[1:0] < 2 ? 2 - i[1:0] : 0) + i[2], 1'b0, 1'b0);
			acc(1'b1, 0, (i[1:0] < 2 ? 2 - i[1:0] : 0) + i[2], 1'b0, 1'b0);
		end
		cfg(4'hA, 1'b0, 2'h2, 2'h2, 1'b0, 1'b1);
		stretch <= 8'h3;
		acc(1'b0, 2, 0, 1'b0, 1'b1);
		give_verdict();
	end
endmodule
